// *** shared/tick_scaler_pkg.sv ***
// Functional notes
// - The tick counter is an 8-bit up-counter, and the scaler in front of it stretches the span to 16 bits.
// - With the option source bit (bit 5) clear, the counter steps every instruction cycle, or on the scaler output when the scaler is assigned to it.
// - With the option source bit (bit 5) set, the counter steps once per valid external pin transition, or on the scaler output when the scaler is assigned.
// - Option bit 4 picks the counting edge of the external pin: one means falling, zero means rising.
// - A wrap of the counter from FFh to 00h raises an interrupt request and sets the rollover flag at bit 7 of timer control B.
// - A software write to the counter also zeroes the scaler count, but only while option bit 3 is zero.
// - A test instruction on the counter suppresses its increment, while a plain read does not.
// - The watchdog counter is 8 bits wide and steps on ticks of its own RC oscillator, not on the instruction clock.
// - Setting option bit 3 puts the scaler behind the watchdog as a postscaler, divided by the three rate bits.
// - Clearing option bit 3 puts the scaler in front of the tick counter with the same rate bits, never serving both.
// - The scaler count is not visible in the register map and cannot be read or written.
// - The rollover interrupt is gated by an enable bit in the option register, apart from the rollover flag.
// - The return-and-add instruction adds the working register value into the tick counter.
package tick_scaler_pkg;
   localparam logic [7:0] OFS_OPTION = 8'h00;
   localparam logic [7:0] OFS_TICK = 8'h04;
   localparam logic [7:0] OFS_CTRL_B = 8'h08;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h0C;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
   localparam logic [7:0] OFS_WATCHDOG = 8'h14;

   localparam int OPT_RATE_LSB = 0;
   localparam int OPT_ASSIGN_BIT = 3;
   localparam int OPT_EDGE_BIT = 4;
   localparam int OPT_SRC_BIT = 5;
   localparam int OPT_IRQ_EN_BIT = 6;
   localparam int CTRL_B_ROLL_BIT = 7;
   localparam int IRQ_ROLL_BIT = 0;
   localparam int IRQ_WDOG_BIT = 1;

   localparam logic [7:0] OPTION_RESET = 8'h3F;
   localparam logic [7:0] TICK_RESET = 8'h00;
   localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
   localparam logic [7:0] COUNT_MAX = 8'hFF;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0]
   {
      BUS_IDLE = 2'b00,
      BUS_RESP = 2'b01
   } bus_state_t;
endpackage

// *** design/scaler_divider.sv ***
module scaler_divider (
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire logic clear_i,
   input wire logic tick_i,
   input wire logic [2:0] rate_i,
   output logic out_o
);
   logic [7:0] count_ff;
   logic out_ff;

   // Ratio 2^(rate+1): all-ones over the selected low bits marks the last tick
   function automatic logic [7:0] rate_mask(input logic [2:0] rate);
      rate_mask = ~8'(9'h1FF << (4'(rate) + 4'h1));
   endfunction

   logic [7:0] mask;
   assign mask = rate_mask(rate_i);

   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         count_ff <= 8'h00;
      else if (clear_i)
         count_ff <= 8'h00;
      else if (tick_i)
         count_ff <= count_ff + 8'h01;
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         out_ff <= 1'b0;
      else
         out_ff <= !clear_i && tick_i && ((count_ff & mask) == mask);
   end

   assign out_o = out_ff;
endmodule

// *** design/tick_counter_watchdog_scaler.sv ***
module tick_counter_watchdog_scaler (
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic count_pin_i,
   input wire logic wdog_osc_tick_i,
   input wire logic wdog_clear_i,
   input wire logic test_access_i,
   input wire logic return_add_work_i,
   input wire logic [7:0] work_value_i,
   output logic irq_o,
   output logic reset_req_o
);
   logic [7:0] option_ff;
   logic [7:0] tick_counter_ff;
   logic [7:0] watchdog_counter_ff;
   logic [1:0] irq_status_ff;
   logic [1:0] irq_mask_ff;
   logic pin_prev_ff;
   logic irq_ff;
   logic reset_req_ff;
   logic aw_held_ff;
   logic w_held_ff;
   logic [7:0] aw_addr_ff;
   logic [7:0] w_data_ff;
   logic w_lane0_ff;
   logic awready_ff;
   logic wready_ff;
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   logic arready_ff;
   logic rvalid_ff;
   logic [1:0] rresp_ff;
   logic [31:0] rdata_ff;
   tick_scaler_pkg::bus_state_t wr_state_ff;

   function automatic logic addr_mapped(input logic [7:0] addr);
      addr_mapped = (addr == tick_scaler_pkg::OFS_OPTION) ||
                    (addr == tick_scaler_pkg::OFS_TICK) ||
                    (addr == tick_scaler_pkg::OFS_CTRL_B) ||
                    (addr == tick_scaler_pkg::OFS_IRQ_STATUS) ||
                    (addr == tick_scaler_pkg::OFS_IRQ_MASK) ||
                    (addr == tick_scaler_pkg::OFS_WATCHDOG);
   endfunction

   // Write channel: address and data are taken in either order
   logic wr_fire;
   logic wr_en;
   assign wr_fire = aw_held_ff && w_held_ff && (wr_state_ff == tick_scaler_pkg::BUS_IDLE);
   assign wr_en = wr_fire && w_lane0_ff && addr_mapped(aw_addr_ff);

   function automatic logic wr_hit(input logic en, input logic [7:0] a, input logic [7:0] ofs);
      wr_hit = en && (a == ofs);
   endfunction

   logic wr_option;
   logic wr_tick;
   logic wr_ctrl_b;
   logic wr_status;
   logic wr_mask;
   logic wr_wdog;
   assign wr_option = wr_hit(wr_en, aw_addr_ff, tick_scaler_pkg::OFS_OPTION);
   assign wr_tick = wr_hit(wr_en, aw_addr_ff, tick_scaler_pkg::OFS_TICK);
   assign wr_ctrl_b = wr_hit(wr_en, aw_addr_ff, tick_scaler_pkg::OFS_CTRL_B);
   assign wr_status = wr_hit(wr_en, aw_addr_ff, tick_scaler_pkg::OFS_IRQ_STATUS);
   assign wr_mask = wr_hit(wr_en, aw_addr_ff, tick_scaler_pkg::OFS_IRQ_MASK);
   assign wr_wdog = wr_hit(wr_en, aw_addr_ff, tick_scaler_pkg::OFS_WATCHDOG);

   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         aw_held_ff <= 1'b0;
         aw_addr_ff <= 8'h00;
         awready_ff <= 1'b1;
      end
      else if (s_axi_awvalid && awready_ff)
      begin
         aw_held_ff <= 1'b1;
         aw_addr_ff <= s_axi_awaddr;
         awready_ff <= 1'b0;
      end
      else if (wr_fire)
         aw_held_ff <= 1'b0;
      else if (!aw_held_ff && !bvalid_ff)
         awready_ff <= 1'b1;
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         w_held_ff <= 1'b0;
         w_data_ff <= 8'h00;
         w_lane0_ff <= 1'b0;
         wready_ff <= 1'b1;
      end
      else if (s_axi_wvalid && wready_ff)
      begin
         w_held_ff <= 1'b1;
         w_data_ff <= s_axi_wdata[7:0];
         w_lane0_ff <= s_axi_wstrb[0];
         wready_ff <= 1'b0;
      end
      else if (wr_fire)
         w_held_ff <= 1'b0;
      else if (!w_held_ff && !bvalid_ff)
         wready_ff <= 1'b1;
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         wr_state_ff <= tick_scaler_pkg::BUS_IDLE;
         bvalid_ff <= 1'b0;
         bresp_ff <= tick_scaler_pkg::RESP_OKAY;
      end
      else
      begin
         case (wr_state_ff)
            tick_scaler_pkg::BUS_IDLE:
            begin
               if (wr_fire)
               begin
                  wr_state_ff <= tick_scaler_pkg::BUS_RESP;
                  bvalid_ff <= 1'b1;
                  bresp_ff <= addr_mapped(aw_addr_ff) ? tick_scaler_pkg::RESP_OKAY :
                                                        tick_scaler_pkg::RESP_SLVERR;
               end
            end
            tick_scaler_pkg::BUS_RESP:
            begin
               if (s_axi_bready)
               begin
                  wr_state_ff <= tick_scaler_pkg::BUS_IDLE;
                  bvalid_ff <= 1'b0;
               end
            end
            default:
            begin
               wr_state_ff <= tick_scaler_pkg::BUS_IDLE;
               bvalid_ff <= 1'b0;
            end
         endcase
      end
   end

   // Read channel; the scaler count has no address at all
   logic [7:0] rd_value;
   always_comb
   begin
      case (s_axi_araddr)
         tick_scaler_pkg::OFS_OPTION: rd_value = option_ff;
         tick_scaler_pkg::OFS_TICK: rd_value = tick_counter_ff;
         tick_scaler_pkg::OFS_CTRL_B:
            rd_value = 8'(irq_status_ff[tick_scaler_pkg::IRQ_ROLL_BIT]) <<
                       tick_scaler_pkg::CTRL_B_ROLL_BIT;
         tick_scaler_pkg::OFS_IRQ_STATUS: rd_value = {6'h00, irq_status_ff};
         tick_scaler_pkg::OFS_IRQ_MASK: rd_value = {6'h00, irq_mask_ff};
         tick_scaler_pkg::OFS_WATCHDOG: rd_value = watchdog_counter_ff;
         default: rd_value = 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         arready_ff <= 1'b1;
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= tick_scaler_pkg::RESP_OKAY;
      end
      else if (s_axi_arvalid && arready_ff)
      begin
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b1;
         rdata_ff <= {24'h000000, rd_value};
         rresp_ff <= addr_mapped(s_axi_araddr) ? tick_scaler_pkg::RESP_OKAY :
                                                tick_scaler_pkg::RESP_SLVERR;
      end
      else if (rvalid_ff && s_axi_rready)
      begin
         rvalid_ff <= 1'b0;
         arready_ff <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         option_ff <= tick_scaler_pkg::OPTION_RESET;
      else if (wr_option)
         option_ff <= w_data_ff;
   end

   logic scaler_to_wdog;
   logic src_external;
   logic edge_falling;
   logic [2:0] rate_sel;
   assign scaler_to_wdog = option_ff[tick_scaler_pkg::OPT_ASSIGN_BIT];
   assign src_external = option_ff[tick_scaler_pkg::OPT_SRC_BIT];
   assign edge_falling = option_ff[tick_scaler_pkg::OPT_EDGE_BIT];
   assign rate_sel = option_ff[tick_scaler_pkg::OPT_RATE_LSB +: 3];

   // External pin edge detect
   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         pin_prev_ff <= 1'b0;
      else
         pin_prev_ff <= count_pin_i;
   end

   logic pin_edge;
   assign pin_edge = edge_falling ? (pin_prev_ff && !count_pin_i) :
                                    (!pin_prev_ff && count_pin_i);

   logic base_tick;
   assign base_tick = src_external ? pin_edge : 1'b1;

   // Watchdog wraps feed the postscaler when assigned there
   logic wdog_wrap;
   assign wdog_wrap = wdog_osc_tick_i && (watchdog_counter_ff == tick_scaler_pkg::COUNT_MAX);

   logic scaler_in;
   logic scaler_out;
   logic scaler_clear;
   logic assign_prev_ff;
   assign scaler_in = scaler_to_wdog ? wdog_wrap : base_tick;
   // Reassignment also restarts the scaler so neither side inherits a stale count
   assign scaler_clear = (wr_tick && !scaler_to_wdog) ||
                         (wdog_clear_i && scaler_to_wdog) ||
                         (assign_prev_ff != scaler_to_wdog);

   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         assign_prev_ff <= tick_scaler_pkg::OPTION_RESET[tick_scaler_pkg::OPT_ASSIGN_BIT];
      else
         assign_prev_ff <= scaler_to_wdog;
   end

   scaler_divider u_scaler (
      .ref_clk_i(ref_clk_i),
      .arst_n_i(arst_n_i),
      .clear_i(scaler_clear),
      .tick_i(scaler_in),
      .rate_i(rate_sel),
      .out_o(scaler_out)
   );

   logic tick_step;
   logic tick_wrap;
   // Scaler output is registered, so a prescaled step lands one cycle after its input
   assign tick_step = (scaler_to_wdog ? base_tick : scaler_out) && !test_access_i;
   assign tick_wrap = tick_step && !wr_tick && !return_add_work_i &&
                      (tick_counter_ff == tick_scaler_pkg::COUNT_MAX);

   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         tick_counter_ff <= tick_scaler_pkg::TICK_RESET;
      else if (wr_tick)
         tick_counter_ff <= w_data_ff;
      else if (return_add_work_i)
         tick_counter_ff <= tick_counter_ff + work_value_i;
      else if (tick_step)
         tick_counter_ff <= tick_counter_ff + 8'h01;
   end

   // Watchdog steps only on its own oscillator ticks
   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         watchdog_counter_ff <= 8'h00;
      else if (wdog_clear_i || wr_wdog)
         watchdog_counter_ff <= 8'h00;
      else if (wdog_osc_tick_i)
         watchdog_counter_ff <= watchdog_counter_ff + 8'h01;
   end

   logic wdog_expire;
   assign wdog_expire = scaler_to_wdog ? scaler_out : wdog_wrap;

   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         reset_req_ff <= 1'b0;
      else
         reset_req_ff <= wdog_expire && !wdog_clear_i;
   end

   // Sticky events: a new event beats a same-cycle clear
   logic [1:0] events;
   logic [1:0] clr_bits;
   assign events = {wdog_expire, tick_wrap};
   always_comb
   begin
      clr_bits = 2'h0;
      if (wr_status)
         clr_bits = w_data_ff[1:0];
      if (wr_ctrl_b && w_data_ff[tick_scaler_pkg::CTRL_B_ROLL_BIT])
         clr_bits[tick_scaler_pkg::IRQ_ROLL_BIT] = 1'b1;
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         irq_status_ff <= 2'h0;
      else
         irq_status_ff <= (irq_status_ff & ~clr_bits) | events;
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         irq_mask_ff <= tick_scaler_pkg::IRQ_MASK_RESET;
      else if (wr_mask)
         irq_mask_ff <= w_data_ff[1:0];
   end

   logic [1:0] gate;
   assign gate = {1'b1, option_ff[tick_scaler_pkg::OPT_IRQ_EN_BIT]};

   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         irq_ff <= 1'b0;
      else
         irq_ff <= |(irq_status_ff & irq_mask_ff & gate);
   end

   assign s_axi_awready = awready_ff;
   assign s_axi_wready = wready_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rresp = rresp_ff;
   assign s_axi_rdata = rdata_ff;
   assign irq_o = irq_ff;
   assign reset_req_o = reset_req_ff;
endmodule

// *** sim/tcws_checker_assertions.sv ***
module tcws_checker (
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic wdog_osc_tick_i,
   input wire logic reset_req_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!arst_n_i);
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read response dropped");
   property p_r_upper;
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
   endproperty
   a_r_upper: assert property (p_r_upper) else $error("read data upper bits set");
   property p_unmapped;
      s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h14
         |=> s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
   property p_b_lat;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
   endproperty
   a_b_lat: assert property (p_b_lat) else $error("write response late");
   property p_busy;
      s_axi_bvalid || s_axi_rvalid |-> !(s_axi_bvalid && s_axi_awready) && !(s_axi_rvalid && s_axi_arready);
   endproperty
   a_busy: assert property (p_busy) else $error("ready while answering");
   property p_rst_pulse;
      reset_req_o |=> !reset_req_o;
   endproperty
   a_rst_pulse: assert property (p_rst_pulse) else $error("reset request too long");
   property p_rst_cause;
      reset_req_o |-> $past(wdog_osc_tick_i) || $past(wdog_osc_tick_i, 2)
         || $past(wdog_osc_tick_i, 3);
   endproperty
   a_rst_cause: assert property (p_rst_cause) else $error("expiry without tick");
   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
   c_expire: cover property (reset_req_o);
endmodule

bind tick_counter_watchdog_scaler tcws_checker u_tcws_checker (.ref_clk_i, .arst_n_i,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
   .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .wdog_osc_tick_i,
   .reset_req_o);

// *** sim/edge_source.sv ***
module edge_source (
   input wire logic ref_clk_i,
   output logic count_pin_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial count_pin_o = 1'b0;
   // Level held a few cycles so every edge is sampled
   task automatic drive(input logic lvl);
      @(posedge ref_clk_i);
      count_pin_o <= lvl;
      repeat (4) @(posedge ref_clk_i);
   endtask
endmodule

// *** sim/tick_counter_watchdog_scaler_tb_top.sv ***
module tick_counter_watchdog_scaler_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] A_OPT = tick_scaler_pkg::OFS_OPTION;
   localparam logic [7:0] A_TCK = tick_scaler_pkg::OFS_TICK;
   localparam logic [7:0] A_CTB = tick_scaler_pkg::OFS_CTRL_B;
   localparam logic [7:0] A_STS = tick_scaler_pkg::OFS_IRQ_STATUS;
   localparam logic [7:0] A_MSK = tick_scaler_pkg::OFS_IRQ_MASK;
   localparam logic [7:0] A_WDG = tick_scaler_pkg::OFS_WATCHDOG;
   logic ref_clk_i, arst_n_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic s_axi_rready, count_pin_i, wdog_osc_tick_i, wdog_clear_i, test_access_i;
   logic return_add_work_i, irq_o, reset_req_o;
   logic [7:0] s_axi_awaddr, s_axi_araddr, work_value_i;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [31:0] d;
   int err_total = 0;
   int samples_checked = 0;
   int wd_hits = 0;

   tick_counter_watchdog_scaler u_tick_counter_watchdog_scaler (.*);
   edge_source u_edge_source (.ref_clk_i(ref_clk_i), .count_pin_o(count_pin_i));

   always @(posedge ref_clk_i)
      if (reset_req_o === 1'b1)
         wd_hits <= wd_hits + 1;

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Local done flags: the ready signals just driven are not visible yet
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      int n = 0;
      logic aw_done = 1'b0;
      logic w_done = 1'b0;
      logic b_done = 1'b0;
      @(posedge ref_clk_i);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (n < 100 && !b_done)
      begin
         @(posedge ref_clk_i);
         n++;
         if (!aw_done && s_axi_awready)
         begin
            aw_done = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_done && s_axi_wready)
         begin
            w_done = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
         if (s_axi_bvalid)
         begin
            b_done = 1'b1;
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
         end
      end
      if (!b_done)
      begin
         err_total++;
         give_verdict();
      end
   endtask

   task automatic rd(input logic [7:0] a);
      int n = 0;
      logic ar_done = 1'b0;
      logic r_done = 1'b0;
      @(posedge ref_clk_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (n < 100 && !r_done)
      begin
         @(posedge ref_clk_i);
         n++;
         if (!ar_done && s_axi_arready)
         begin
            ar_done = 1'b1;
            s_axi_arvalid <= 1'b0;
         end
         if (s_axi_rvalid)
         begin
            r_done = 1'b1;
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
         end
      end
      if (!r_done)
      begin
         err_total++;
         give_verdict();
      end
   endtask

   // Counter runs for exactly n sampled edges, then freezes again
   task automatic run(input int n);
      @(posedge ref_clk_i);
      test_access_i <= 1'b0;
      repeat (n) @(posedge ref_clk_i);
      test_access_i <= 1'b1;
   endtask

   task automatic osc(input int n);
      repeat (n)
      begin
         @(posedge ref_clk_i);
         wdog_osc_tick_i <= 1'b1;
         @(posedge ref_clk_i);
         wdog_osc_tick_i <= 1'b0;
      end
   endtask

   task automatic t_reset;
      rd(A_OPT);
      chk(d, 32'h3F);
      rd(A_TCK);
      chk(d, 32'h0);
      rd(8'h18);
      chk({r, d[29:0]}, {tick_scaler_pkg::RESP_SLVERR, 30'h0});
      wr(8'h18, 32'h5A);
      chk(r, tick_scaler_pkg::RESP_SLVERR);
      $display("reset done");
   endtask

   task automatic t_internal;
      wr(A_OPT, 32'h08);
      chk(r, tick_scaler_pkg::RESP_OKAY);
      wr(A_TCK, 32'h10);
      repeat (30) @(posedge ref_clk_i);
      rd(A_TCK);
      chk(d, 32'h10);
      run(20);
      rd(A_TCK);
      chk(d, 32'h24);
      // Window is a whole number of scaler periods, so exactly 16 steps
      for (int k = 0; k < 8; k++)
      begin
         wr(A_OPT, k);
         wr(A_TCK, 32'h0);
         run(16 << (k + 1));
         rd(A_TCK);
         chk(d, 32'h10);
      end
      // Rate 7 left set: the tick write restarts the scaler, so no step for 256 cycles
      wr(A_TCK, 32'h0);
      run(200);
      rd(A_TCK);
      chk(d, 32'h0);
      $display("internal done");
   endtask

   task automatic t_pin;
      wr(A_OPT, 32'h28);
      @(posedge ref_clk_i);
      test_access_i <= 1'b0;
      wr(A_TCK, 32'h0);
      u_edge_source.drive(1'b1);
      rd(A_TCK);
      chk(d, 32'h1);
      u_edge_source.drive(1'b0);
      wr(A_OPT, 32'h38);
      rd(A_TCK);
      chk(d, 32'h1);
      u_edge_source.drive(1'b1);
      u_edge_source.drive(1'b0);
      rd(A_TCK);
      chk(d, 32'h2);
      test_access_i <= 1'b1;
      $display("pin done");
   endtask

   task automatic t_roll;
      wr(A_OPT, 32'h48);
      wr(A_MSK, 32'h1);
      wr(A_TCK, 32'hFF);
      run(3);
      rd(A_TCK);
      chk(d, 32'h2);
      rd(A_CTB);
      chk(d, 32'h80);
      chk(irq_o, 32'h1);
      wr(A_OPT, 32'h08);
      repeat (2) @(posedge ref_clk_i);
      chk(irq_o, 32'h0);
      wr(A_STS, 32'h1);
      rd(A_STS);
      chk(d, 32'h0);
      wr(A_TCK, 32'hF0);
      @(posedge ref_clk_i);
      work_value_i <= 8'h20;
      return_add_work_i <= 1'b1;
      @(posedge ref_clk_i);
      return_add_work_i <= 1'b0;
      rd(A_TCK);
      chk(d, 32'h10);
      $display("rollover done");
   endtask

   task automatic t_wdog;
      wr(A_OPT, 32'h00);
      wr(A_MSK, 32'h2);
      wr(A_WDG, 32'h0);
      repeat (50) @(posedge ref_clk_i);
      rd(A_WDG);
      chk(d, 32'h0);
      osc(255);
      rd(A_WDG);
      chk(d, 32'hFF);
      chk(wd_hits, 32'h0);
      osc(1);
      repeat (4) @(posedge ref_clk_i);
      chk(wd_hits, 32'h1);
      rd(A_STS);
      chk(d, 32'h2);
      chk(irq_o, 32'h1);
      wr(A_STS, 32'h2);
      repeat (2) @(posedge ref_clk_i);
      chk(irq_o, 32'h0);
      osc(3);
      @(posedge ref_clk_i);
      wdog_clear_i <= 1'b1;
      @(posedge ref_clk_i);
      wdog_clear_i <= 1'b0;
      rd(A_WDG);
      chk(d, 32'h0);
      // Postscaler at ratio 2: only every second wrap expires
      wr(A_OPT, 32'h08);
      wr(A_WDG, 32'h0);
      osc(256);
      repeat (4) @(posedge ref_clk_i);
      chk(wd_hits, 32'h1);
      osc(256);
      repeat (4) @(posedge ref_clk_i);
      chk(wd_hits, 32'h2);
      $display("watchdog done");
   endtask

   initial
   begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end

   initial
   begin
      {arst_n_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
      {s_axi_rready, wdog_osc_tick_i, wdog_clear_i, return_add_work_i} = '0;
      {s_axi_awaddr, s_axi_araddr, work_value_i, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      test_access_i = 1'b1;
      repeat (12) @(posedge ref_clk_i);
      arst_n_i <= 1'b1;
      t_reset();
      t_internal();
      t_pin();
      t_roll();
      t_wdog();
      give_verdict();
   end
endmodule
